// ===== core/pdsr_pkg.sv
package pdsr_pkg;
   localparam int ADDR_W = 7;
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] HDR_LAST = 5'h07;
   localparam logic [4:0] FRAME_LAST = 5'h0f;
   localparam logic [4:0] CNT_MAX = 5'h10;
   localparam logic [4:0] OUT_START = 5'h08;
   localparam logic [6:0] OBUF_ADDR = 7'h09;
   localparam logic [6:0] MASK_ADDR = 7'h0d;
   localparam logic [6:0] SYNC_ADDR = 7'h0e;
   localparam logic [6:0] AIN_ADDR = 7'h11;
   localparam logic [7:0] OBUF_RESET = 8'h0c;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] SYNC_RESET = 8'h00;
   localparam logic [7:0] AIN_RESET = 8'h00;
   localparam logic [7:0] OBUF_WMASK = 8'h3f;
   localparam logic [7:0] MASK_WMASK = 8'h0e;
   localparam logic [7:0] SYNC_WMASK = 8'hef;
   localparam logic [7:0] AIN_WMASK = 8'h20;
   localparam int FRAME_CLOCK_BIT = 5;
   localparam int BIT_CLOCK_BIT = 4;
   localparam int A1_BIT = 3;
   localparam int A0_BIT = 2;
   localparam int B1_BIT = 1;
   localparam int B0_BIT = 0;
   localparam int KEEP_CLK_BIT = 3;
   localparam int KEEP_REF_BIT = 2;
   localparam int BG_OFF_BIT = 1;
   localparam int PIN_SYNC_BIT = 7;
   localparam int REG_SYNC_BIT = 6;
   localparam int REG_SYNC_EN_BIT = 5;
   localparam int REF_REG_BIT = 3;
   localparam int REF_SEL_HI = 2;
   localparam int REF_SEL_LO = 1;
   localparam int SE_CLK_BIT = 0;
   localparam int SE_A_BIT = 5;
   localparam logic [1:0] REF_INTERNAL = 2'h0;
   localparam logic [1:0] REF_EXT_BUFFERED = 2'h1;
   localparam logic [1:0] REF_EXT_DIRECT = 2'h2;
   localparam int PIN_N = 5;
   // Serial enable idles high, every other pin idles low
   localparam logic [4:0] PIN_RESET = 5'h10;
   typedef struct packed {
      logic frame_clock;
      logic bit_clock;
      logic a1;
      logic a0;
      logic b1;
      logic b0;
   } lane_off_t;
endpackage

// ===== core/powerdown_sync_ref_control.sv
// Functional notes
// [R1] Output register bit 5 set powers down the frame clock output buffer.
// [R2] Output register bit 4 set powers down the bit clock output buffer.
// [R3] Bit 3 or one-wire/half-wire mode powers down channel A lane 1.
// [R4] Bit 2 set powers down the channel A lane 0 buffer.
// [R5] Bit 1 or one-wire/half-wire mode powers down channel B lane 1.
// [R6] Bit 0 or half-wire mode powers down channel B lane 0.
// [R7] Mask bit 3 keeps the sampling clock buffer on in global sleep.
// [R8] Mask bit 2 keeps the reference amplifier on in global sleep.
// [R9] Mask bit 1 set lets global sleep also switch off the bandgap.
// [R10] Sync bit 7 picks pin high as global sleep or sync command.
// [R11] Raising bit 6 from 0 to 1 issues sync when bit 5 set; never self-cleared.
// [R12] Bit 5 set takes sync from register bit instead of the pin.
// [R13] Bit 3 clear lets the reference pin choose; set uses register bits.
// [R14] Bits 2-1 pick internal, external buffered or external direct reference.
// [R15] Bit 0 with bit 3 selects single-ended clock, differential buffer off.
// [R16] Analog input bit 5 selects single-ended channel A input.
// [R17] Global sleep bit switches off blocks chosen by the mask register.
// [R18] Software writes zero to reserved bits.
module powerdown_sync_ref_control (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              clk_en,
   input  wire logic              spi_sclk,
   input  wire logic              spi_sen_n,
   input  wire logic              spi_sdi,
   output logic                   spi_sdo,
   input  wire logic              sync_powerdown_pin,
   input  wire logic              reference_buffer_pin,
   input  wire logic              global_sleep_bit,
   input  wire logic              one_wire_mode,
   input  wire logic              half_wire_mode,
   output pdsr_pkg::lane_off_t    lane_off,
   output logic                   global_powerdown,
   output logic                   clock_buffer_off,
   output logic                   reference_amp_off,
   output logic                   bandgap_off,
   output logic                   sync_command,
   output logic                   reference_by_register,
   output logic [1:0]             reference_select,
   output logic                   reference_pin_level,
   output logic                   single_ended_clock_select,
   output logic                   chan_a_single_ended_input
);
   // Pin order: sen_n, sclk, sdi, sync pin, reference_buffer_pin pin
   logic [pdsr_pkg::PIN_N-1:0] meta_q, meta_d, pin_q, pin_d;
   logic sclk_prev_q, sclk_prev_d, spin_prev_q, spin_prev_d;
   logic [4:0]  cnt_q, cnt_d;
   logic [14:0] shift_q, shift_d;
   logic [7:0]  rd_q, rd_d;
   logic [7:0]  obuf_q, obuf_d, mask_q, mask_d, sync_q, sync_d, ain_q, ain_d;
   logic        sync6_prev_q, sync6_prev_d;
   pdsr_pkg::lane_off_t lane_d;
   logic gpd_d, clkbuf_d, refamp_d, bg_d, synccmd_d, refreg_d, refpin_d;
   logic secl_d, sea_d;
   logic [1:0] refsel_d;

   function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] wm);
      masked = data & wm;
   endfunction

   function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] o,
                                           input logic [7:0] m, input logic [7:0] s,
                                           input logic [7:0] n);
      case (a)
         pdsr_pkg::OBUF_ADDR: read_reg = o;
         pdsr_pkg::MASK_ADDR: read_reg = m;
         pdsr_pkg::SYNC_ADDR: read_reg = s;
         pdsr_pkg::AIN_ADDR:  read_reg = n;
         default:             read_reg = 8'h00;
      endcase
   endfunction

   // Serial port and register bank
   logic sen_n_s, sclk_s, sdi_s, spin_s, rpin_s, rise, fall;
   always_comb begin
      meta_d = {spi_sen_n, spi_sclk, spi_sdi, sync_powerdown_pin, reference_buffer_pin};
      pin_d = meta_q;
      {sen_n_s, sclk_s, sdi_s, spin_s, rpin_s} = pin_q;
      rise = sclk_s & ~sclk_prev_q;
      fall = ~sclk_s & sclk_prev_q;
      sclk_prev_d = sclk_s;
      spin_prev_d = spin_s;
      sync6_prev_d = sync_q[pdsr_pkg::REG_SYNC_BIT];
      cnt_d = cnt_q;
      shift_d = shift_q;
      rd_d = rd_q;
      obuf_d = obuf_q;
      mask_d = mask_q;
      sync_d = sync_q;
      ain_d = ain_q;
      if (sen_n_s) begin
         cnt_d = 5'h00;
         rd_d = 8'h00;
      end else if (rise && cnt_q != pdsr_pkg::CNT_MAX) begin
         shift_d = {shift_q[13:0], sdi_s};
         cnt_d = cnt_q + 5'h01;
         if (cnt_q == pdsr_pkg::HDR_LAST && shift_q[6]) begin
            rd_d = read_reg({shift_q[5:0], sdi_s}, obuf_q, mask_q, sync_q, ain_q);
         end
         if (cnt_q == pdsr_pkg::FRAME_LAST && !shift_q[14]) begin
            // Reserved bits dropped on write, read back as zero [R18]
            case (shift_q[13:7])
               pdsr_pkg::OBUF_ADDR:
                  obuf_d = masked({shift_q[6:0], sdi_s}, pdsr_pkg::OBUF_WMASK);
               pdsr_pkg::MASK_ADDR:
                  mask_d = masked({shift_q[6:0], sdi_s}, pdsr_pkg::MASK_WMASK);
               pdsr_pkg::SYNC_ADDR:
                  sync_d = masked({shift_q[6:0], sdi_s}, pdsr_pkg::SYNC_WMASK); // [R11]
               pdsr_pkg::AIN_ADDR:
                  ain_d = masked({shift_q[6:0], sdi_s}, pdsr_pkg::AIN_WMASK);
               default: ;
            endcase
         end
      end else if (fall && cnt_q > pdsr_pkg::OUT_START) begin
         rd_d = {rd_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= pdsr_pkg::PIN_RESET;
         pin_q <= pdsr_pkg::PIN_RESET;
         sclk_prev_q <= 1'b0;
         spin_prev_q <= 1'b0;
         sync6_prev_q <= 1'b0;
         cnt_q <= 5'h00;
         shift_q <= 15'h0000;
         rd_q <= 8'h00;
         obuf_q <= pdsr_pkg::OBUF_RESET;
         mask_q <= pdsr_pkg::MASK_RESET;
         sync_q <= pdsr_pkg::SYNC_RESET;
         ain_q <= pdsr_pkg::AIN_RESET;
      end else if (clk_en) begin
         meta_q <= meta_d;
         pin_q <= pin_d;
         sclk_prev_q <= sclk_prev_d;
         spin_prev_q <= spin_prev_d;
         sync6_prev_q <= sync6_prev_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         rd_q <= rd_d;
         obuf_q <= obuf_d;
         mask_q <= mask_d;
         sync_q <= sync_d;
         ain_q <= ain_d;
      end
   end

   assign spi_sdo = rd_q[7];

   // Registered control outputs
   logic reg_sync_en, pin_is_sync;
   always_comb begin
      reg_sync_en = sync_q[pdsr_pkg::REG_SYNC_EN_BIT];
      pin_is_sync = sync_q[pdsr_pkg::PIN_SYNC_BIT];
      lane_d.frame_clock = obuf_q[pdsr_pkg::FRAME_CLOCK_BIT]; // [R1]
      lane_d.bit_clock = obuf_q[pdsr_pkg::BIT_CLOCK_BIT]; // [R2]
      lane_d.a1 = obuf_q[pdsr_pkg::A1_BIT] | one_wire_mode | half_wire_mode; // [R3]
      lane_d.a0 = obuf_q[pdsr_pkg::A0_BIT]; // [R4]
      lane_d.b1 = obuf_q[pdsr_pkg::B1_BIT] | one_wire_mode | half_wire_mode; // [R5]
      lane_d.b0 = obuf_q[pdsr_pkg::B0_BIT] | half_wire_mode; // [R6]
      gpd_d = global_sleep_bit | (spin_s & ~pin_is_sync); // [R10] [R17]
      clkbuf_d = (gpd_d & ~mask_q[pdsr_pkg::KEEP_CLK_BIT]) // [R7]
               | (sync_q[pdsr_pkg::REF_REG_BIT] & sync_q[pdsr_pkg::SE_CLK_BIT]); // [R15]
      refamp_d = gpd_d & ~mask_q[pdsr_pkg::KEEP_REF_BIT]; // [R8]
      bg_d = gpd_d & mask_q[pdsr_pkg::BG_OFF_BIT]; // [R9]
      // Register edge only when enabled, pin edge only when not [R11] [R12]
      synccmd_d = (reg_sync_en & sync_q[pdsr_pkg::REG_SYNC_BIT] & ~sync6_prev_q)
                | (~reg_sync_en & pin_is_sync & spin_s & ~spin_prev_q); // [R10]
      refreg_d = sync_q[pdsr_pkg::REF_REG_BIT]; // [R13]
      refsel_d = refreg_d ? sync_q[pdsr_pkg::REF_SEL_HI:pdsr_pkg::REF_SEL_LO]
                          : pdsr_pkg::REF_INTERNAL; // [R14]
      refpin_d = ~refreg_d & rpin_s; // [R13]
      secl_d = refreg_d & sync_q[pdsr_pkg::SE_CLK_BIT]; // [R15]
      sea_d = ain_q[pdsr_pkg::SE_A_BIT]; // [R16]
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lane_off <= '0;
         global_powerdown <= 1'b0;
         clock_buffer_off <= 1'b0;
         reference_amp_off <= 1'b0;
         bandgap_off <= 1'b0;
         sync_command <= 1'b0;
         reference_by_register <= 1'b0;
         reference_select <= pdsr_pkg::REF_INTERNAL;
         reference_pin_level <= 1'b0;
         single_ended_clock_select <= 1'b0;
         chan_a_single_ended_input <= 1'b0;
      end else if (clk_en) begin
         lane_off <= lane_d;
         global_powerdown <= gpd_d;
         clock_buffer_off <= clkbuf_d;
         reference_amp_off <= refamp_d;
         bandgap_off <= bg_d;
         sync_command <= synccmd_d;
         reference_by_register <= refreg_d;
         reference_select <= refsel_d;
         reference_pin_level <= refpin_d;
         single_ended_clock_select <= secl_d;
         chan_a_single_ended_input <= sea_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence reg_sync_rise;
      clk_en && sync_q[pdsr_pkg::REG_SYNC_BIT] && !sync6_prev_q;
   endsequence
   sequence reg_sync_armed;
      clk_en && sync_q[pdsr_pkg::REG_SYNC_EN_BIT];
   endsequence

   frame_lane_off_a: assert property (clk_en |=> // [R1]
      lane_off.frame_clock == $past(obuf_q[5]))
      else $error("frame clock buffer off mismatch");
   lane_a1_off_a: assert property (clk_en && (one_wire_mode || half_wire_mode) |=> // [R3]
      lane_off.a1)
      else $error("lane a1 not off in narrow mode");
   lane_b0_off_a: assert property (clk_en |=> // [R6]
      lane_off.b0 == ($past(obuf_q[0]) || $past(half_wire_mode)))
      else $error("lane b0 off mismatch");
   keep_clock_a: assert property (clk_en && mask_q[3] |=> !clock_buffer_off // [R7]
      || single_ended_clock_select)
      else $error("clock buffer off despite keep mask");
   bandgap_sense_a: assert property (clk_en && !mask_q[1] |=> !bandgap_off) // [R9]
      else $error("bandgap off with mask clear");
   pin_sleep_a: assert property (clk_en && pin_q[1] && !sync_q[7] |=> global_powerdown) // [R10]
      else $error("pin high did not put device to sleep");
   reg_sync_a: assert property (reg_sync_rise and reg_sync_armed |=> sync_command) // [R11]
      else $error("register sync not issued");
   sync_hold_a: assert property (clk_en && sync_q[6] && !(rise && cnt_q == 5'h0f) // [R11]
      |=> sync_q[6])
      else $error("sync bit cleared without a write");
   pin_sync_block_a: assert property (clk_en && sync_q[5] && !sync_q[6] |=> // [R12]
      !sync_command)
      else $error("sync issued while register sync idle");
   ref_select_a: assert property (clk_en && !sync_q[3] |=> reference_select == 2'h0 // [R14]
      && !single_ended_clock_select)
      else $error("register reference used while pin controls");
   se_input_a: assert property (clk_en |=> chan_a_single_ended_input == $past(ain_q[5])) // [R16]
      else $error("single ended input select mismatch");

   // Lane buffer fields
   bit_lane_off_a: assert property (clk_en |=> // [R2]
      lane_off.bit_clock == $past(obuf_q[pdsr_pkg::BIT_CLOCK_BIT]))
      else $error("bit clock buffer off mismatch");
   lane_a0_off_a: assert property (clk_en |=> // [R4]
      lane_off.a0 == $past(obuf_q[pdsr_pkg::A0_BIT]))
      else $error("lane a0 off mismatch");
   lane_b1_off_a: assert property (clk_en && (one_wire_mode || half_wire_mode) |=> // [R5]
      lane_off.b1)
      else $error("lane b1 not off in narrow mode");

   // Global sleep and its mask
   sleep_bit_a: assert property (clk_en && global_sleep_bit |=> // [R17]
      global_powerdown)
      else $error("sleep bit did not put device to sleep");
   freeze_sleep_a: assert property (!clk_en |=> // [R17]
      $stable(global_powerdown))
      else $error("sleep output moved while frozen");
   clock_sleep_a: assert property (clk_en && global_sleep_bit // [R7]
      && !mask_q[pdsr_pkg::KEEP_CLK_BIT] |=> clock_buffer_off)
      else $error("clock buffer left on in sleep");
   keep_ref_a: assert property (clk_en && mask_q[pdsr_pkg::KEEP_REF_BIT] |=> // [R8]
      !reference_amp_off)
      else $error("reference amp off despite keep mask");
   ref_amp_sleep_a: assert property (clk_en && global_sleep_bit // [R8]
      && !mask_q[pdsr_pkg::KEEP_REF_BIT] |=> reference_amp_off)
      else $error("reference amp left on in sleep");
   bandgap_sleep_a: assert property (clk_en && global_sleep_bit // [R9]
      && mask_q[pdsr_pkg::BG_OFF_BIT] |=> bandgap_off)
      else $error("bandgap left on in sleep with mask set");

   // Pin sync path
   sequence pin_sync_rise;
      clk_en && pin_q[1] && !spin_prev_q;
   endsequence
   sequence pin_sync_armed;
      clk_en && sync_q[pdsr_pkg::PIN_SYNC_BIT] && !sync_q[pdsr_pkg::REG_SYNC_EN_BIT];
   endsequence
   pin_sync_a: assert property (pin_sync_rise and pin_sync_armed |=> sync_command) // [R10]
      else $error("pin sync not issued");
   pin_no_sleep_a: assert property (clk_en && sync_q[pdsr_pkg::PIN_SYNC_BIT] // [R10]
      && !global_sleep_bit |=> !global_powerdown)
      else $error("pin in sync role put device to sleep");
   reg_sync_off_a: assert property (clk_en && !sync_q[pdsr_pkg::REG_SYNC_EN_BIT] // [R12]
      && !sync_q[pdsr_pkg::PIN_SYNC_BIT] |=> !sync_command)
      else $error("sync issued with both sync paths off");

   // Reference and clock select
   ref_pin_a: assert property (clk_en && !sync_q[pdsr_pkg::REF_REG_BIT] |=> // [R13]
      reference_pin_level == $past(pin_q[0]))
      else $error("reference pin level not passed through");
   ref_code_a: assert property (clk_en && sync_q[pdsr_pkg::REF_REG_BIT] |=> // [R14]
      reference_select == $past(sync_q[pdsr_pkg::REF_SEL_HI:pdsr_pkg::REF_SEL_LO]))
      else $error("register reference code not applied");
   se_clock_a: assert property (clk_en && sync_q[pdsr_pkg::REF_REG_BIT] // [R15]
      && sync_q[pdsr_pkg::SE_CLK_BIT] |=> single_ended_clock_select && clock_buffer_off)
      else $error("single ended clock not applied");
endmodule

// ===== tb/test_powerdown_sync_ref_control.sv
module test_powerdown_sync_ref_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk;
   logic                reset_n;
   logic                clk_en;
   logic                spi_sclk;
   logic                spi_sen_n;
   logic                spi_sdi;
   logic                spi_sdo;
   logic                sync_powerdown_pin;
   logic                reference_buffer_pin;
   logic                global_sleep_bit;
   logic                one_wire_mode;
   logic                half_wire_mode;
   pdsr_pkg::lane_off_t lane_off;
   logic                global_powerdown;
   logic                clock_buffer_off;
   logic                reference_amp_off;
   logic                bandgap_off;
   logic                sync_command;
   logic                reference_by_register;
   logic [1:0]          reference_select;
   logic                reference_pin_level;
   logic                single_ended_clock_select;
   logic                chan_a_single_ended_input;
   logic [7:0]          rd;
   int                  errors = 0;
   int                  n_compared = 0;
   int                  pulses = 0;
   int                  p0;
   localparam logic [6:0] ADDRS [5] = '{7'h09, 7'h0d, 7'h0e, 7'h11, 7'h20};
   localparam logic [7:0] RSTV [5] = '{8'h0c, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] WMSK [5] = '{8'h3f, 8'h0e, 8'hef, 8'h20, 8'h00};
   // Writable bits only; the unmapped slot gets all ones
   localparam logic [7:0] WVAL [5] = '{8'h3f, 8'h0e, 8'hef, 8'h20, 8'hff};
   localparam logic [7:0] MVALS [5] = '{8'h00, 8'h0e, 8'h08, 8'h06, 8'h02};

   powerdown_sync_ref_control i_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
      .spi_sclk(spi_sclk), .spi_sen_n(spi_sen_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
      .sync_powerdown_pin(sync_powerdown_pin), .reference_buffer_pin(reference_buffer_pin),
      .global_sleep_bit(global_sleep_bit), .one_wire_mode(one_wire_mode),
      .half_wire_mode(half_wire_mode), .lane_off(lane_off),
      .global_powerdown(global_powerdown), .clock_buffer_off(clock_buffer_off),
      .reference_amp_off(reference_amp_off), .bandgap_off(bandgap_off),
      .sync_command(sync_command), .reference_by_register(reference_by_register),
      .reference_select(reference_select), .reference_pin_level(reference_pin_level),
      .single_ended_clock_select(single_ended_clock_select),
      .chan_a_single_ended_input(chan_a_single_ended_input));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   always @(posedge clk) if (sync_command === 1'b1) pulses <= pulses + 1;

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One 16-bit frame, slow serial clock so the synchronisers keep up
   task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d);
      logic [15:0] f;
      f = {rw, a, d};
      spi_sen_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_sdi = f[i];
         spi_sclk = 1'b0;
         step(6);
         if (i < 8) rd[i] = spi_sdo;
         spi_sclk = 1'b1;
         step(6);
      end
      spi_sclk = 1'b0;
      step(6);
      spi_sen_n = 1'b1;
      step(6);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      xfer(1'b0, a, d);
   endtask

   task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
      xfer(1'b1, a, 8'h00);
      check(rd, exp);
   endtask

   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      complete_run();
   end

   initial begin
      {reset_n, spi_sclk, spi_sdi, sync_powerdown_pin, reference_buffer_pin} = '0;
      {global_sleep_bit, one_wire_mode, half_wire_mode} = '0;
      spi_sen_n = 1'b1;
      clk_en = 1'b1;
      repeat (20) @(posedge clk);
      #1 reset_n = 1'b1;
      step(1);
      check({global_powerdown, sync_command}, 8'h00);
      step(3);
      check({2'b00, lane_off}, 8'h0c);
      for (int i = 0; i < 5; i++) rdchk(ADDRS[i], RSTV[i]);
      for (int i = 0; i < 5; i++) begin
         wr(ADDRS[i], WVAL[i]);
         rdchk(ADDRS[i], WMSK[i]);
         wr(ADDRS[i], 8'h00);
      end
      $display("test registers done");
      for (int b = 0; b < 6; b++) begin
         wr(7'h09, 8'h01 << b);
         step(3);
         check({2'b00, lane_off}, 8'h01 << b);
      end
      wr(7'h09, 8'h00);
      one_wire_mode = 1'b1;
      step(4);
      check({2'b00, lane_off}, 8'h0a);
      one_wire_mode = 1'b0;
      half_wire_mode = 1'b1;
      step(4);
      check({2'b00, lane_off}, 8'h0b);
      half_wire_mode = 1'b0;
      $display("test lanes done");
      global_sleep_bit = 1'b1;
      for (int i = 0; i < 5; i++) begin
         wr(7'h0d, MVALS[i]);
         step(3);
         check({global_powerdown, clock_buffer_off, reference_amp_off, bandgap_off},
               {1'b1, ~MVALS[i][3], ~MVALS[i][2], MVALS[i][1]});
      end
      global_sleep_bit = 1'b0;
      step(3);
      check({global_powerdown, clock_buffer_off, reference_amp_off, bandgap_off}, 8'h0);
      clk_en = 1'b0;
      global_sleep_bit = 1'b1;
      step(4);
      check(global_powerdown, 8'h0);
      clk_en = 1'b1;
      step(3);
      check(global_powerdown, 8'h1);
      global_sleep_bit = 1'b0;
      step(3);
      $display("test mask done");
      sync_powerdown_pin = 1'b1;
      step(5);
      check(global_powerdown, 8'h1);
      sync_powerdown_pin = 1'b0;
      wr(7'h0e, 8'h80);
      p0 = pulses;
      sync_powerdown_pin = 1'b1;
      for (int k = 0; k < 20 && pulses == p0; k++) step(1);
      step(4);
      check(8'(pulses - p0), 8'h01);
      check(global_powerdown, 8'h0);
      sync_powerdown_pin = 1'b0;
      wr(7'h0e, 8'h20);
      p0 = pulses;
      wr(7'h0e, 8'h60);
      step(2);
      check(8'(pulses - p0), 8'h01);
      rdchk(7'h0e, 8'h60);
      wr(7'h0e, 8'h00);
      p0 = pulses;
      wr(7'h0e, 8'h40);
      step(4);
      check(8'(pulses - p0), 8'h00);
      wr(7'h0e, 8'ha0);
      sync_powerdown_pin = 1'b1;
      step(8);
      check(8'(pulses - p0), 8'h00);
      sync_powerdown_pin = 1'b0;
      $display("test sync done");
      for (int c = 0; c < 3; c++) begin
         wr(7'h0e, 8'h08 | 8'(c << 1));
         step(3);
         check({reference_by_register, reference_select}, 8'h04 | 8'(c));
      end
      wr(7'h0e, 8'h09);
      step(3);
      check({single_ended_clock_select, clock_buffer_off}, 8'h03);
      wr(7'h0e, 8'h05);
      reference_buffer_pin = 1'b1;
      step(5);
      check({reference_by_register, reference_select, reference_pin_level,
             single_ended_clock_select}, 8'h02);
      wr(7'h11, 8'h20);
      step(3);
      check(chan_a_single_ended_input, 8'h1);
      wr(7'h11, 8'h00);
      step(3);
      check(chan_a_single_ended_input, 8'h0);
      $display("test reference done");
      reset_n = 1'b0;
      step(2);
      check({2'b00, lane_off}, 8'h00);
      reset_n = 1'b1;
      step(1);
      check({2'b00, lane_off}, 8'h0c);
      rdchk(7'h0e, 8'h00);
      $display("test reset done");
      complete_run();
   end
endmodule
